// >>> logic/lutdac_pkg.sv
package lutdac_pkg;

	// Memory map, byte addresses on the serial side
	localparam logic [8:0] ADDR_CTRL0      = 9'h080;
	localparam logic [8:0] ADDR_CTRL1      = 9'h081;
	localparam logic [8:0] ADDR_CTRL2      = 9'h082;
	localparam logic [8:0] ADDR_CTRL3      = 9'h083;
	localparam logic [8:0] ADDR_CTRL4      = 9'h084;
	localparam logic [8:0] ADDR_CTRL5      = 9'h085;
	localparam logic [8:0] ADDR_WRITE_EN   = 9'h086;
	localparam logic [8:0] ADDR_ADC_STATUS = 9'h087;
	localparam logic [8:0] BASE_TABLE_ONE  = 9'h090;
	localparam logic [8:0] BASE_TABLE_TWO  = 9'h0D0;

	// Table geometry
	localparam int         TABLE_ROWS      = 64;
	localparam int         ROW_BITS        = 6;

	// Control register 0 fields
	localparam int         REF_SOURCE_BIT  = 0;
	localparam int         CONV_INPUT_BIT  = 3;
	localparam int         FILTER_BYP_BIT  = 6;

	// Control register 5 fields
	localparam int         DAC2_DIRECT_BIT = 7;
	localparam int         TAB2_DIRECT_BIT = 6;
	localparam int         DAC1_DIRECT_BIT = 5;
	localparam int         TAB1_DIRECT_BIT = 4;

	// Write-enable control register
	localparam int         WRITE_LATCH_POS = 7;
	localparam logic [7:0] LATCH_SET_VAL   = 8'h80;
	localparam logic [7:0] LATCH_CLR_VAL   = 8'h00;

	// Reset values
	localparam logic [7:0] CTRL_RESET      = 8'h00;
	localparam logic [7:0] DAC_HOLD_VAL    = 8'h00;
	localparam logic [7:0] TABLE_RESET     = 8'h00;

	// Settling filter: identical high bits needed before an update
	localparam logic [1:0] AGREE_LAST      = 2'h3;

endpackage

// >>> logic/lutdac_control.sv
`timescale 1ns/1ps
`default_nettype none

module lutdac_control (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst,
	// Byte writes from the serial protocol engine
	input  wire logic       memWrStrobe,
	input  wire logic [8:0] memWrAddr,
	input  wire logic [7:0] memWrData,
	output logic            memWrAck,
	output logic            memWrNack,
	// Byte reads from the serial protocol engine
	input  wire logic       memRdStrobe,
	input  wire logic [8:0] memRdAddr,
	output logic [7:0]      memRdData,
	output logic            memRdValid,
	// Converter interface
	input  wire logic       convDone,
	input  wire logic [7:0] convValue,
	output logic            refPinDrive,
	output logic            senseInputSel,
	// DAC input bytes
	output logic [7:0]      dac1Input,
	output logic [7:0]      dac2Input
);

	////////////////////////////////////////////////////////////////////////
	function automatic logic tableHit(input logic [8:0] addr, input logic [8:0] base);
		tableHit = (addr >= base) && (addr < base + 9'(lutdac_pkg::TABLE_ROWS));
	endfunction

	function automatic logic [5:0] rowOf(input logic [8:0] addr, input logic [8:0] base);
		logic [8:0] diff;
		diff  = addr - base;
		rowOf = diff[5:0];
	endfunction

	logic [7:0] ctrl_q [0:5];
	logic [7:0] tableOne_q [0:lutdac_pkg::TABLE_ROWS-1];
	logic [7:0] tableTwo_q [0:lutdac_pkg::TABLE_ROWS-1];
	logic       writeLatch_q;
	logic [7:0] result_q;
	logic       resultValid_q;
	logic [5:0] prevHigh_q;
	logic [1:0] agree_q;
	logic       havePrev_q;

	logic wrLatchReg;
	logic wrAllowed;
	assign wrLatchReg = memWrAddr == lutdac_pkg::ADDR_WRITE_EN;
	assign wrAllowed  = memWrStrobe && writeLatch_q && !wrLatchReg;

	////////////////////////////////////////////////////////////////////////
	// Write-enable latch; only the latch bit exists, reserved bits stay zero
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			writeLatch_q <= 1'b0;
		end else if (memWrStrobe && wrLatchReg) begin
			if (memWrData == lutdac_pkg::LATCH_SET_VAL) begin
				writeLatch_q <= 1'b1;
			end else if (memWrData == lutdac_pkg::LATCH_CLR_VAL) begin
				writeLatch_q <= 1'b0;
			end
		end
	end

	// Acknowledge is decided the cycle after the byte arrives
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			memWrAck  <= 1'b0;
			memWrNack <= 1'b0;
		end else begin
			memWrAck  <= memWrStrobe && (writeLatch_q || wrLatchReg);
			memWrNack <= memWrStrobe && !writeLatch_q && !wrLatchReg;
		end
	end

	// Control registers 0..5
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 6; i++) begin
				ctrl_q[i] <= lutdac_pkg::CTRL_RESET;
			end
		end else if (wrAllowed && memWrAddr >= lutdac_pkg::ADDR_CTRL0
				&& memWrAddr <= lutdac_pkg::ADDR_CTRL5) begin
			ctrl_q[memWrAddr[2:0]] <= memWrData;
		end
	end

	// Look-up tables; reset stands in for the factory-cleared contents
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < lutdac_pkg::TABLE_ROWS; i++) begin
				tableOne_q[i] <= lutdac_pkg::TABLE_RESET;
				tableTwo_q[i] <= lutdac_pkg::TABLE_RESET;
			end
		end else if (wrAllowed) begin
			if (tableHit(memWrAddr, lutdac_pkg::BASE_TABLE_ONE)) begin
				tableOne_q[rowOf(memWrAddr, lutdac_pkg::BASE_TABLE_ONE)] <= memWrData;
			end else if (tableHit(memWrAddr, lutdac_pkg::BASE_TABLE_TWO)) begin
				tableTwo_q[rowOf(memWrAddr, lutdac_pkg::BASE_TABLE_TWO)] <= memWrData;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read port; general memory and reserved addresses read zero here
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			memRdData  <= 8'h00;
			memRdValid <= 1'b0;
		end else begin
			memRdValid <= memRdStrobe;
			if (memRdStrobe) begin
				if (memRdAddr >= lutdac_pkg::ADDR_CTRL0 && memRdAddr <= lutdac_pkg::ADDR_CTRL5) begin
					memRdData <= ctrl_q[memRdAddr[2:0]];
				end else if (memRdAddr == lutdac_pkg::ADDR_WRITE_EN) begin
					memRdData <= {writeLatch_q, 7'h00};
				end else if (memRdAddr == lutdac_pkg::ADDR_ADC_STATUS) begin
					memRdData <= result_q;
				end else if (tableHit(memRdAddr, lutdac_pkg::BASE_TABLE_ONE)) begin
					memRdData <= tableOne_q[rowOf(memRdAddr, lutdac_pkg::BASE_TABLE_ONE)];
				end else if (tableHit(memRdAddr, lutdac_pkg::BASE_TABLE_TWO)) begin
					memRdData <= tableTwo_q[rowOf(memRdAddr, lutdac_pkg::BASE_TABLE_TWO)];
				end else begin
					memRdData <= 8'h00;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Settling filter and result register; no bus path writes result_q
	logic       filterByp;
	logic [1:0] agreeNext;
	assign filterByp = ctrl_q[0][lutdac_pkg::FILTER_BYP_BIT];
	// Reset contents of prevHigh_q are not a conversion, so they never count as agreement
	assign agreeNext = (!havePrev_q || convValue[7:2] != prevHigh_q) ? 2'h0
		: (agree_q == lutdac_pkg::AGREE_LAST) ? agree_q : agree_q + 2'h1;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			prevHigh_q    <= 6'h00;
			agree_q       <= 2'h0;
			havePrev_q    <= 1'b0;
			result_q      <= 8'h00;
			resultValid_q <= 1'b0;
		end else if (convDone) begin
			prevHigh_q <= convValue[7:2];
			agree_q    <= agreeNext;
			havePrev_q <= 1'b1;
			// Count 0 means one conversion seen, so count 3 is the fourth alike
			if (filterByp || agreeNext == lutdac_pkg::AGREE_LAST) begin
				result_q      <= convValue;
				resultValid_q <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Row selection and DAC sources, refreshed every clock
	logic [5:0] rowOne;
	logic [5:0] rowTwo;
	logic       oneRowDirect;
	logic       twoRowDirect;
	logic       oneDacDirect;
	logic       twoDacDirect;
	assign oneRowDirect = ctrl_q[5][lutdac_pkg::TAB1_DIRECT_BIT];
	assign twoRowDirect = ctrl_q[5][lutdac_pkg::TAB2_DIRECT_BIT];
	assign oneDacDirect = ctrl_q[5][lutdac_pkg::DAC1_DIRECT_BIT];
	assign twoDacDirect = ctrl_q[5][lutdac_pkg::DAC2_DIRECT_BIT];
	assign rowOne = oneRowDirect ? ctrl_q[1][5:0] : result_q[7:2];
	assign rowTwo = twoRowDirect ? ctrl_q[2][5:0] : result_q[7:2];

	// Hold at zero until a lookup is possible; direct modes need no conversion
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			dac1Input <= lutdac_pkg::DAC_HOLD_VAL;
			dac2Input <= lutdac_pkg::DAC_HOLD_VAL;
		end else begin
			if (oneDacDirect) begin
				dac1Input <= ctrl_q[3];
			end else if (resultValid_q || oneRowDirect) begin
				dac1Input <= tableOne_q[rowOne];
			end else begin
				dac1Input <= lutdac_pkg::DAC_HOLD_VAL;
			end
			if (twoDacDirect) begin
				dac2Input <= ctrl_q[4];
			end else if (resultValid_q || twoRowDirect) begin
				dac2Input <= tableTwo_q[rowTwo];
			end else begin
				dac2Input <= lutdac_pkg::DAC_HOLD_VAL;
			end
		end
	end

	// Analog selects
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			refPinDrive   <= 1'b1;
			senseInputSel <= 1'b0;
		end else begin
			refPinDrive   <= !ctrl_q[0][lutdac_pkg::REF_SOURCE_BIT];
			senseInputSel <= ctrl_q[0][lutdac_pkg::CONV_INPUT_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	chk_latch_set: assert property (memWrStrobe && wrLatchReg
		&& memWrData == lutdac_pkg::LATCH_SET_VAL |=> writeLatch_q && memWrAck)
		else $error("write latch not set by 80h");
	chk_latch_clear: assert property (memWrStrobe && wrLatchReg
		&& memWrData == lutdac_pkg::LATCH_CLR_VAL |=> !writeLatch_q && memWrAck)
		else $error("write latch not cleared by 00h");
	chk_locked_nack: assert property (memWrStrobe && !writeLatch_q && !wrLatchReg
		|=> memWrNack && !memWrAck && $stable(ctrl_q[0]))
		else $error("locked write was accepted");
	chk_latch_ack: assert property (memWrStrobe && wrLatchReg |=> memWrAck)
		else $error("latch register byte not acknowledged");
	chk_status_readonly: assert property (memWrStrobe
		&& memWrAddr == lutdac_pkg::ADDR_ADC_STATUS && !convDone |=> $stable(result_q))
		else $error("status write changed result");
	chk_bypass_update: assert property (convDone && filterByp
		|=> result_q == $past(convValue))
		else $error("bypassed filter missed an update");
	chk_filter_hold: assert property (convDone && !filterByp
		&& convValue[7:2] != prevHigh_q |=> $stable(result_q))
		else $error("filter updated without agreement");
	chk_dac2_direct: assert property (twoDacDirect ##1 twoDacDirect
		|-> dac2Input == $past(ctrl_q[4]))
		else $error("direct byte not on second DAC");
	chk_dac_hold: assert property (!resultValid_q && !oneRowDirect && !oneDacDirect
		|=> dac1Input == lutdac_pkg::DAC_HOLD_VAL)
		else $error("first DAC left hold early");

	cov_latch_set: cover property (memWrStrobe && wrLatchReg ##1 writeLatch_q);
	cov_filter_load: cover property (convDone && !filterByp ##1 resultValid_q);
	cov_direct_dac2: cover property (twoDacDirect && resultValid_q);
	cov_locked_nack: cover property (memWrNack);

endmodule

`default_nettype wire

// >>> test/lutdac_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module lutdac_host_model (
	// Clock
	input  wire logic       clk_sys,
	// Byte writes
	output logic            memWrStrobe,
	output logic [8:0]      memWrAddr,
	output logic [7:0]      memWrData,
	input  wire logic       memWrAck,
	input  wire logic       memWrNack,
	// Byte reads
	output logic            memRdStrobe,
	output logic [8:0]      memRdAddr,
	input  wire logic [7:0] memRdData,
	input  wire logic       memRdValid
);
	initial begin
		memWrStrobe = 1'b0;
		memRdStrobe = 1'b0;
		memWrAddr   = 9'h000;
		memRdAddr   = 9'h000;
		memWrData   = 8'h00;
	end
	////////////////////////////////////////////////////////////////
	// One-cycle strobe, answer sampled once the next edge has landed
	task automatic wr(input logic [8:0] a, input logic [7:0] d, output logic ack,
		output logic nack);
		@(posedge clk_sys);
		memWrStrobe <= 1'b1;
		memWrAddr   <= a;
		memWrData   <= d;
		@(posedge clk_sys);
		memWrStrobe <= 1'b0;
		// Stale data is inverted so a late sample cannot pass by luck
		memWrData   <= ~d;
		#1;
		ack  = memWrAck;
		nack = memWrNack;
	endtask
	task automatic rd(input logic [8:0] a, output logic [7:0] d, output logic ok);
		@(posedge clk_sys);
		memRdStrobe <= 1'b1;
		memRdAddr   <= a;
		@(posedge clk_sys);
		memRdStrobe <= 1'b0;
		#1;
		d  = memRdData;
		ok = memRdValid;
	endtask
endmodule
`default_nettype wire

// >>> test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic       clk_sys, rst, convDone, memWrStrobe, memWrAck, memWrNack, memRdStrobe;
	logic       memRdValid, refPinDrive, senseInputSel, ack, nack;
	logic [8:0] memWrAddr, memRdAddr;
	logic [7:0] convValue, memWrData, memRdData, dac1Input, dac2Input, res, v;
	logic [7:0] t1 [64];
	logic [7:0] t2 [64];
	logic [7:0] ctrl [6];
	int         nFail = 0, cmpCount = 0, cycles = 0, seed;

	lutdac_control DUT (.clk_sys, .rst, .memWrStrobe, .memWrAddr, .memWrData, .memWrAck,
		.memWrNack, .memRdStrobe, .memRdAddr, .memRdData, .memRdValid, .convDone,
		.convValue, .refPinDrive, .senseInputSel, .dac1Input, .dac2Input);
	lutdac_host_model host (.clk_sys, .memWrStrobe, .memWrAddr, .memWrData, .memWrAck,
		.memWrNack, .memRdStrobe, .memRdAddr, .memRdData, .memRdValid);

	always #2.5 clk_sys = ~clk_sys;
	////////////////////////////////////////////////////////////////
	// Direct byte beats direct row, which beats the converter row
	function automatic logic [7:0] expDac(input logic two);
		logic [5:0] r;
		if (two ? ctrl[5][7] : ctrl[5][5]) return two ? ctrl[4] : ctrl[3];
		r = ctrl[5][two ? 6 : 4] ? ctrl[two ? 2 : 1][5:0] : res[7:2];
		return two ? t2[r] : t1[r];
	endfunction
	task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
		cmpCount++;
		if (g !== e) begin
			nFail++;
			$display("FAIL %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic put(input logic [8:0] a, input logic [7:0] d, input logic e);
		host.wr(a, d, ack, nack);
		chk("ack", {7'h00, e}, {7'h00, ack});
		chk("nack", {7'h00, !e}, {7'h00, nack});
	endtask
	task automatic get(input logic [8:0] a, input logic [7:0] e);
		host.rd(a, v, ack);
		chk("valid", 8'h01, {7'h00, ack});
		chk("rdata", e, v);
	endtask
	task automatic cfg(input logic [2:0] i, input logic [7:0] d);
		ctrl[i] = d;
		put({6'h10, i}, d, 1'b1);
	endtask
	task automatic conv(input logic [7:0] d);
		@(posedge clk_sys);
		convDone  <= 1'b1;
		convValue <= d;
		@(posedge clk_sys);
		convDone  <= 1'b0;
		convValue <= ~d;
	endtask
	task automatic dacs;
		repeat (3) @(posedge clk_sys);
		#1;
		chk("dac1", expDac(1'b0), dac1Input);
		chk("dac2", expDac(1'b1), dac2Input);
	endtask
	task automatic finish_test;
		$display("Counts: %0d compared, %0d failed", cmpCount, nFail);
		if (nFail == 0 && cmpCount > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 8000) begin
			nFail++;
			finish_test();
		end
	end
	////////////////////////////////////////////////////////////////
	initial begin
		clk_sys   = 1'b0;
		rst       = 1'b1;
		convDone  = 1'b0;
		convValue = 8'h00;
		seed      = 32'h5C72;
		res       = 8'h00;
		ctrl      = '{default: 8'h00};
		t1        = '{default: 8'h00};
		t2        = '{default: 8'h00};
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		#1;
		chk("dac1", 8'h00, dac1Input);
		chk("dac2", 8'h00, dac2Input);
		chk("ref", 8'h01, {7'h00, refPinDrive});
		chk("sense", 8'h00, {7'h00, senseInputSel});
		get(9'h086, 8'h00);
		put(9'h090, 8'h5A, 1'b0);
		put(9'h086, 8'h80, 1'b1);
		get(9'h086, 8'h80);
		$display("test latch set done");
		for (int i = 0; i < 64; i++) begin
			t1[i] = 8'($random(seed));
			t2[i] = 8'($random(seed));
			put(9'h090 + 9'(i), t1[i], 1'b1);
			put(9'h0D0 + 9'(i), t2[i], 1'b1);
		end
		// Top bit forced so the first sample never matches the reset state
		v = 8'($random(seed)) | 8'h80;
		res = {v[7:2], 2'h3};
		for (int i = 0; i < 3; i++)
			conv({res[7:2], 2'(i)});
		get(9'h087, 8'h00);
		chk("dac1", 8'h00, dac1Input);
		conv(res);
		get(9'h087, res);
		dacs();
		conv(~res);
		get(9'h087, res);
		$display("test filter done");
		cfg(3'h0, 8'h49);
		repeat (2) @(posedge clk_sys);
		#1;
		chk("ref", 8'h00, {7'h00, refPinDrive});
		chk("sense", 8'h01, {7'h00, senseInputSel});
		for (int i = 0; i < 8; i++) begin
			res = 8'($random(seed));
			conv(res);
			get(9'h087, res);
			dacs();
		end
		put(9'h087, ~res, 1'b1);
		get(9'h087, res);
		$display("test bypass done");
		for (int k = 0; k < 16; k++) begin
			for (int i = 1; i < 5; i++)
				cfg(3'(i), 8'($random(seed)));
			cfg(3'h5, {4'(k), 4'h0});
			dacs();
		end
		$display("test sources done");
		cfg(3'h5, 8'h50);
		put(9'h086, 8'h00, 1'b1);
		get(9'h086, 8'h00);
		put(9'h081, ~ctrl[1], 1'b0);
		dacs();
		put(9'h086, 8'h55, 1'b1);
		get(9'h086, 8'h00);
		$display("test latch clear done");
		// Reset in mid-run must drop a set latch and return the selects to default
		put(9'h086, 8'h80, 1'b1);
		@(posedge clk_sys);
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		#1;
		chk("dac1", 8'h00, dac1Input);
		chk("dac2", 8'h00, dac2Input);
		chk("ref", 8'h01, {7'h00, refPinDrive});
		chk("sense", 8'h00, {7'h00, senseInputSel});
		get(9'h086, 8'h00);
		put(9'h081, 8'h3F, 1'b0);
		$display("test reset done");
		finish_test();
	end
endmodule
`default_nettype wire
